// >>> hdl/odsw_defs.vh
/*
 Constants for the serial write host of an octal DAC.
 Assumes a 100 MHz system clock; included by bare name.
*/
// Operation
// - Host drives frame select low before sending a word.
// - Byte-oriented port gives eight falling edges per byte.
// - Keep frame select low between first and second byte.
// - Raise frame select only after the second byte completes.
// - Words go out most significant bit first.
// - Least-first hardware must reverse byte bit order before sending.
// - Clock polarity arranged so the converter samples on falling edges.
// - All converters share one serial clock and one data line.
// - At most one converter frame select asserted at any time.
// - Decoder enable held inactive while address inputs change.
`ifndef ODSW_DEFS_VH
`define ODSW_DEFS_VH
`define ODSW_WORD_BITS 16
`define ODSW_BYTE_BITS 8
`define ODSW_CNT_W 5
`define ODSW_HALF_DIV 8
`define ODSW_DIV_W 4
`define ODSW_SEL_N 4
`define ODSW_ADDR_W 2
`define ODSW_SETTLE 2
`endif

// >>> hdl/odsw_host.v
/*
 Host that writes 16-bit words to one of several octal DACs
 sharing a serial clock and data line, each with its own select.
 Assumes words arrive on a valid/ready port in the mclk_i domain.
*/
`include "odsw_defs.vh"
module odsw_host #(
  parameter WORD_W = `ODSW_WORD_BITS,
  parameter SEL_N = `ODSW_SEL_N,
  parameter ADDR_W = `ODSW_ADDR_W,
  parameter HALF_DIV = `ODSW_HALF_DIV
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [WORD_W-1:0] word_i,
  input wire [ADDR_W-1:0] addr_i,
  input wire valid_i,
  output wire ready_o,
  output reg sclk_o,
  output reg sdata_o,
  output wire [SEL_N-1:0] sync_n_o,
  output reg busy_o
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  reg rst_s1_q;
  reg rst_s2_q;
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_n = rst_s2_q;

  // ----------------------------------------
  // Two-entry buffer
  // ----------------------------------------
  reg [WORD_W+ADDR_W-1:0] buf_q [0:1];
  reg wp_q;
  reg rp_q;
  reg [1:0] cnt_q;
  wire buf_pop;
  wire buf_push = valid_i && (cnt_q != 2'd2);
  assign ready_o = (cnt_q != 2'd2);
  wire buf_valid = (cnt_q != 2'd0);
  wire [WORD_W+ADDR_W-1:0] buf_head = buf_q[rp_q];
  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'd0;
      buf_q[0] <= {(WORD_W+ADDR_W){1'b0}};
      buf_q[1] <= {(WORD_W+ADDR_W){1'b0}};
    end
    else
    begin
      if (buf_push)
      begin
        buf_q[wp_q] <= {addr_i, word_i};
        wp_q <= ~wp_q;
      end
      if (buf_pop)
        rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // ----------------------------------------
  // Frame engine
  // ----------------------------------------
  localparam S_IDLE = 4'b0001;
  localparam S_SEL = 4'b0010;
  localparam S_SHIFT = 4'b0100;
  localparam S_END = 4'b1000;

  reg [3:0] st_q;
  reg [WORD_W-1:0] sh_q;
  reg [ADDR_W-1:0] addr_q;
  reg [`ODSW_CNT_W-1:0] bit_q;
  reg [`ODSW_DIV_W-1:0] div_q;
  reg sel_en_q;
  wire tick = (div_q == HALF_DIV[`ODSW_DIV_W-1:0] - 4'd1);
  assign buf_pop = (st_q == S_IDLE) && buf_valid;

  function [SEL_N-1:0] dec_sel;
    input en;
    input [ADDR_W-1:0] a;
    begin
      dec_sel = {SEL_N{1'b0}};
      if (en)
        dec_sel[a] = 1'b1;
    end
  endfunction

  // ----------------------------------------
  // Half-period divider
  // ----------------------------------------
  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= {`ODSW_DIV_W{1'b0}};
    else if (tick)
      div_q <= {`ODSW_DIV_W{1'b0}};
    else
      div_q <= div_q + 4'd1;
  end

  // ----------------------------------------
  // Shift sequencer
  // ----------------------------------------
  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= S_IDLE;
      sh_q <= {WORD_W{1'b0}};
      addr_q <= {ADDR_W{1'b0}};
      bit_q <= {`ODSW_CNT_W{1'b0}};
      sclk_o <= 1'b1;
      sdata_o <= 1'b0;
    end
    else
    begin
      case (st_q)
        S_IDLE:
        begin
          sclk_o <= 1'b1;
          if (buf_valid)
          begin
            addr_q <= buf_head[WORD_W+ADDR_W-1:WORD_W];
            sh_q <= buf_head[WORD_W-1:0];
            st_q <= S_SEL;
          end
        end
        S_SEL:
          if (tick)
          begin
            sdata_o <= sh_q[WORD_W-1];
            bit_q <= {`ODSW_CNT_W{1'b0}};
            st_q <= S_SHIFT;
          end
        S_SHIFT:
          if (tick)
          begin
            if (sclk_o)
              sclk_o <= 1'b0;
            else
            begin
              sclk_o <= 1'b1;
              sh_q <= {sh_q[WORD_W-2:0], 1'b0};
              sdata_o <= sh_q[WORD_W-2];
              bit_q <= bit_q + 5'd1;
              if (bit_q == WORD_W[`ODSW_CNT_W-1:0] - 5'd1)
                st_q <= S_END;
            end
          end
        S_END:
          if (tick)
          begin
            st_q <= S_IDLE;
          end
        default:
          st_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Frame selects
  // ----------------------------------------
  reg sel_en_d;
  reg [SEL_N-1:0] sync_q;
  always @*
  begin
    sel_en_d = sel_en_q;
    case (st_q)
      S_IDLE:
        sel_en_d = 1'b0;
      S_SEL:
        if (tick)
          sel_en_d = 1'b1;
      S_SHIFT:
        sel_en_d = 1'b1;
      S_END:
        if (tick)
          sel_en_d = 1'b0;
      default:
        sel_en_d = 1'b0;
    endcase
  end

  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_en_q <= 1'b0;
      sync_q <= {SEL_N{1'b1}};
    end
    else
    begin
      sel_en_q <= sel_en_d;
      sync_q <= ~dec_sel(sel_en_d, addr_q);
    end
  end
  assign sync_n_o = sync_q;

  // ----------------------------------------
  // Status
  // ----------------------------------------
  always @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      busy_o <= 1'b0;
    else
      busy_o <= buf_valid || (st_q != S_IDLE);
  end
endmodule

// >>> tb/odsw_dac_model.sv
/* Model of one converter's serial write port.
 Expects shared clock and data, own select. */
module odsw_dac_model (
  input wire sclk_i,
  input wire sdata_i,
  input wire sync_n_i,
  output logic [15:0] word_o = 0,
  output logic [7:0] got_o = 0,
  output logic [4:0] bits_o = 0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] sh;
  always @(negedge sync_n_i) bits_o = 0;
  always @(negedge sclk_i)
    if (!sync_n_i)
    begin
      sh = {sh[14:0], sdata_i};
      bits_o++;
      if (bits_o == 16)
      begin
        word_o = sh;
        got_o++;
      end
    end
endmodule

// >>> tb/odsw_host_asserts.sv
/* Pin checker for the host. Bound into odsw_host. */
module odsw_host_asserts #(
  parameter SEL_N = 4
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire sclk_o,
  input wire sdata_o,
  input wire [SEL_N-1:0] sync_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire idle = &sync_n_o;
  a_one_select: assert property ($onehot0(~sync_n_o))
    else $error("two selects");
  a_clk_framed: assert property ($fell(sclk_o) |-> !idle)
    else $error("edge unframed");
  a_lead_time: assert property ($fell(idle) |-> sclk_o [*8])
    else $error("lead short");
  a_data_held: assert property ($fell(sclk_o) |-> $stable(sdata_o))
    else $error("data moved");
  a_low_half: assert property ($fell(sclk_o) |-> !sclk_o [*8])
    else $error("half short");
  a_sel_steady: assert property (!sclk_o |-> $stable(sync_n_o))
    else $error("select moved");
  a_end_high: assert property ($rose(idle) |-> $past(sclk_o, 4))
    else $error("early end");
  a_no_glitch: assert property (!idle |=> idle || $stable(sync_n_o))
    else $error("select glitch");
  c_start: cover property ($fell(idle));
  c_end: cover property ($rose(idle));
  c_clk: cover property ($fell(sclk_o));
endmodule
bind odsw_host odsw_host_asserts #(.SEL_N(SEL_N)) chk (.mclk_i(mclk_i),
  .rst_n_i(rst_n_i),
  .sclk_o(sclk_o), .sdata_o(sdata_o), .sync_n_o(sync_n_o));

// >>> tb/tb.sv
/* Bench for odsw_host with four converter models. */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst_n = 0, valid = 0, ready, sclk, sdata, busy;
  logic [15:0] word = 0;
  logic [1:0] addr = 0;
  logic [3:0] sync_n;
  wire [63:0] w;
  wire [31:0] g;
  wire [19:0] b;
  int n_fail = 0, check_count = 0;
  wire [7:0] tot = g[7:0] + g[15:8] + g[23:16] + g[31:24];
  odsw_host dut (.mclk_i(mclk), .rst_n_i(rst_n), .word_i(word),
    .addr_i(addr), .valid_i(valid), .ready_o(ready), .sclk_o(sclk),
    .sdata_o(sdata), .sync_n_o(sync_n), .busy_o(busy));
  odsw_dac_model dac[3:0] (.sclk_i(sclk), .sdata_i(sdata),
    .sync_n_i(sync_n), .word_o(w), .got_o(g), .bits_o(b));
  initial forever #5 mclk = ~mclk;
  task chk(input string s, input logic [15:0] e, input logic [15:0] v);
    check_count++;
    if (v !== e)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", s, e, v);
    end
  endtask
  task results;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task send(input logic [15:0] x, input logic [1:0] a);
    @(posedge mclk);
    word <= x;
    addr <= a;
    valid <= 1;
    @(negedge mclk);
    while (ready !== 1) @(negedge mclk);
    @(posedge mclk);
    valid <= 0;
  endtask
  task drain(input int n);
    repeat (3000) @(negedge mclk) if (tot == n) break;
    chk("count", n, tot);
  endtask
  task s_each;
    for (int a = 0; a < 4; a++)
    begin
      send(16'hc3a0 + a, a);
      drain(a + 1);
      chk("word", 16'hc3a0 + a, w[16*a+:16]);
      chk("bits", 16, b[5*a+:5]);
    end
  endtask
  task s_burst;
    send(16'h0001, 3);
    send(16'hfffe, 2);
    send(16'h5a5a, 1);
    @(negedge mclk);
    chk("full", 0, ready);
    chk("busy", 1, busy);
    send(16'h8421, 0);
    drain(8);
    chk("w3", 16'h0001, w[63:48]);
    chk("w2", 16'hfffe, w[47:32]);
    chk("w1", 16'h5a5a, w[31:16]);
    chk("w0", 16'h8421, w[15:0]);
    wait (sync_n === 4'hf);
    repeat (2) @(negedge mclk);
    chk("sel_end", 16'hf, sync_n);
    chk("busy_end", 0, busy);
    chk("ready_end", 1, ready);
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    rst_n <= 1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk("idle", 16'hf, sync_n);
    chk("busy_rst", 0, busy);
    chk("ready_rst", 1, ready);
    s_each;
    s_burst;
    results;
  end
  initial
  begin
    #200us;
    n_fail++;
    results;
  end
endmodule
